/* File: core/drive_control_status_word.v */
// Purpose: decode the bus command word into drive commands, build the condition word
// Assumes: bus write strobe and condition inputs are on clk; digital inputs are pins
// Notes:   motor control itself is outside; command levels, the trip reset pulse and the command and condition words leave this block
`timescale 1ns/1ps
`include "drive_word_regs.vh"

module drive_control_status_word
(
    input  wire        clk,
    input  wire        arst_n,
    // command word write port
    input  wire        cmd_write,
    input  wire [15:0] cmd_wdata,
    output reg  [15:0] drive_command_word,
    // digital input pins, asynchronous
    input  wire [1:0]  din_ref_sel,
    input  wire        din_coast_n,
    input  wire        din_start,
    input  wire [1:0]  din_setup_sel,
    input  wire        din_reverse,
    input  wire        din_freeze_stop,
    // settings
    input  wire [1:0]  ref_src,
    input  wire [1:0]  coast_src,
    input  wire [1:0]  start_src,
    input  wire [1:0]  setup_src,
    input  wire [1:0]  reverse_src,
    input  wire        relay1_from_bus,
    input  wire        relay2_from_bus,
    input  wire        multi_setup,
    // drive conditions
    input  wire        cond_ctrl_ready,
    input  wire        cond_drive_ready,
    input  wire        cond_trip,
    input  wire        cond_error,
    input  wire        cond_triplock,
    input  wire        cond_warning,
    input  wire        cond_at_ref,
    input  wire        cond_local,
    input  wire        cond_freq_limit,
    input  wire        cond_freq_nonzero,
    input  wire        cond_overtemp,
    input  wire        cond_voltage,
    input  wire        cond_torque,
    input  wire        cond_timer,
    input  wire        cond_link_lost,
    // commands out
    output reg  [1:0]  preset_sel,
    output reg         dc_brake_stop,
    output reg         coast,
    output reg         quick_stop,
    output reg         freeze_freq,
    output reg         ramp_stop,
    output reg         run_permit,
    output reg         trip_reset,
    output reg         jog,
    output reg         ramp2_sel,
    output reg         relay1,
    output reg         relay2,
    output reg  [1:0]  setup_sel,
    output reg         reverse,
    output reg  [15:0] drive_condition_word
);

    // two-flop synchroniser for pin inputs; only stage two is read
    // reset to zero: pin coast stands until the pins are sampled, the safe side
    reg  [7:0]  pin_s1;
    reg  [7:0]  pin_s2;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            pin_s1 <= 8'h00;
            pin_s2 <= 8'h00;
        end
        else
        begin
            pin_s1 <= {din_freeze_stop, din_reverse, din_setup_sel, din_start,
                       din_coast_n, din_ref_sel};
            pin_s2 <= pin_s1;
        end
    end

    wire [1:0]  s_ref    = pin_s2[1:0];
    wire        s_coastn = pin_s2[2];
    wire        s_start  = pin_s2[3];
    wire [1:0]  s_setup  = pin_s2[5:4];
    wire        s_rev    = pin_s2[6];
    wire        s_fstop  = pin_s2[7];

    // combine bus and pin per source setting
    // an unknown code falls back to the pin, like the default source
    function [1:0] merge;
        input [1:0] src;
        input [1:0] bus;
        input [1:0] pin;
        begin
            case (src)
                `SRC_DIGITAL: merge = pin;
                `SRC_BUS:     merge = bus;
                `SRC_AND:     merge = bus & pin;
                `SRC_OR:      merge = bus | pin;
                default:      merge = pin;
            endcase
        end
    endfunction

    // only valid words reach the hold register
    // a word with bit 10 clear is dropped whole, so no field leaks through
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            drive_command_word <= `CMD_RESET_VAL;
        else if (cmd_write && cmd_wdata[`CMD_VALID])
            drive_command_word <= cmd_wdata;
    end

    wire [15:0] w = drive_command_word;
    // reset value has bit 10 clear, so no command gated by v acts before the first word
    wire        v = w[`CMD_VALID];

    wire [1:0]  ref_m   = merge(ref_src, w[`CMD_REF_MSB:`CMD_REF_LSB], s_ref);
    wire [1:0]  coast_m = merge(coast_src, {1'b0, w[`CMD_COAST]}, {1'b0, s_coastn});
    wire [1:0]  start_m = merge(start_src, {1'b0, w[`CMD_START]}, {1'b0, s_start});
    wire [1:0]  setup_m = merge(setup_src, w[`CMD_SETUP_MSB:`CMD_SETUP_LSB], s_setup);
    wire [1:0]  rev_m   = merge(reverse_src, {1'b0, w[`CMD_REVERSE]}, {1'b0, s_rev});

    // freeze request from a valid word
    wire        frozen     = v & ~w[`CMD_HOLD];
    // dc brake request from a valid word
    wire        brake_req  = v & ~w[`CMD_DC_BRAKE];
    // pin stop only counts while frozen
    wire        pin_stop   = frozen & s_fstop;

    // previous reset bit, a steady level gives no pulse
    reg         cmd_prev_reset;
    wire        reset_edge = v & w[`CMD_RESET] & ~cmd_prev_reset;

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cmd_prev_reset <= 1'b0;
            trip_reset     <= 1'b0;
        end
        else
        begin
            cmd_prev_reset <= w[`CMD_RESET];
            // one-cycle pulse on the leading edge
            trip_reset     <= reset_edge;
        end
    end

    // stop levels: a low bus bit means stop, so reset leaves coast and ramp stop on
    // settings are taken as steady levels on clk, not synchronised
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            preset_sel    <= 2'h0;
            dc_brake_stop <= 1'b0;
            coast         <= 1'b1;
            quick_stop    <= 1'b0;
            freeze_freq   <= 1'b0;
            ramp_stop     <= 1'b1;
            run_permit    <= 1'b0;
            jog           <= 1'b0;
            ramp2_sel     <= 1'b0;
        end
        else
        begin
            preset_sel    <= ref_m;

            dc_brake_stop <= brake_req;

            coast         <= ~coast_m[0];

            quick_stop    <= v & ~w[`CMD_QSTOP] & ~frozen;

            freeze_freq   <= frozen;

            // ramp stop on low start bit, not while frozen
            ramp_stop     <= ~start_m[0] & ~frozen;

            run_permit    <= start_m[0] & coast_m[0] & ~brake_req & ~pin_stop;

            jog           <= v & w[`CMD_JOG];

            ramp2_sel     <= v & w[`CMD_RAMP_SEL];
        end
    end

    // relays, set-up and direction
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            relay1    <= 1'b0;
            relay2    <= 1'b0;
            setup_sel <= 2'h0;
            reverse   <= 1'b0;
        end
        else
        begin
            // relays gated by function setting
            // a relay not given to the bus stays off whatever its bit says
            relay1    <= v & w[`CMD_RELAY1] & relay1_from_bus;
            relay2    <= v & w[`CMD_RELAY2] & relay2_from_bus;

            // single set-up keeps the last choice
            if (multi_setup)
                setup_sel <= setup_m;
            // pin source ignores bus bit 15
            reverse   <= (reverse_src == `SRC_DIGITAL) ? s_rev : rev_m[0];
        end
    end

    // status bits are built here and registered below
    reg  [15:0] next_condition_word;

    always @*
    begin
        // bit 5 stays zero from this default
        next_condition_word     = 16'h0000;
        // ready, drive ready under coast, enable
        next_condition_word[0]  = cond_ctrl_ready & ~cond_trip;
        next_condition_word[1]  = cond_drive_ready & coast;
        next_condition_word[2]  = ~coast;

        // trip, error without trip, trip lock
        next_condition_word[3]  = cond_trip;
        next_condition_word[4]  = cond_error & ~cond_trip;
        next_condition_word[6]  = cond_triplock;

        next_condition_word[7]  = cond_warning;

        next_condition_word[8]  = cond_at_ref;

        next_condition_word[9]  = ~cond_local;
        next_condition_word[10] = ~cond_freq_limit;

        // start signal or output frequency
        // the registered run permit makes this trail a start by one edge
        next_condition_word[11] = run_permit | cond_freq_nonzero;

        next_condition_word[12] = cond_overtemp;
        next_condition_word[13] = cond_voltage;
        next_condition_word[14] = cond_torque;
        next_condition_word[15] = cond_timer;

        // link loss clears every bit, over any condition
        if (cond_link_lost)
            next_condition_word = 16'h0000;
    end

    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            drive_condition_word <= 16'h0000;
        else
            drive_condition_word <= next_condition_word;
    end

endmodule // drive_control_status_word

/* File: include/drive_word_regs.vh */
// Purpose: bit positions for the drive command word and settings codes for the source selects
// Assumes: 16-bit words, bit 0 least significant
// Notes:   source select codes are shared by all combinable functions
`ifndef DRIVE_WORD_REGS_VH
`define DRIVE_WORD_REGS_VH

`define CMD_WIDTH        16
`define CMD_RESET_VAL    16'h0000
`define CMD_REF_LSB      0
`define CMD_REF_MSB      1
`define CMD_DC_BRAKE     2
`define CMD_COAST        3
`define CMD_QSTOP        4
`define CMD_HOLD         5
`define CMD_START        6
`define CMD_RESET        7
`define CMD_JOG          8
`define CMD_RAMP_SEL     9
`define CMD_VALID        10
`define CMD_RELAY1       11
`define CMD_RELAY2       12
`define CMD_SETUP_LSB    13
`define CMD_SETUP_MSB    14
`define CMD_REVERSE      15

// source select: 0 digital input, 1 bus, 2 logic and, 3 logic or
`define SRC_DIGITAL      2'h0
`define SRC_BUS          2'h1
`define SRC_AND          2'h2
`define SRC_OR           2'h3

`endif

/* File: verif/bus_master_model.sv */
// Purpose: far-side master writing whole command words
// Assumes: bench clock, one-cycle write strobe
// Notes:   strobe and data change only at the falling edge
`timescale 1ns/1ps
module bus_master_model
(
    input  wire         clk,
    output logic        cmd_write,
    output logic [15:0] cmd_wdata
);
    initial
    begin
        cmd_write = 1'h0;
        cmd_wdata = 16'h0000;
    end
    task automatic send(input logic [15:0] word);
        @(negedge clk);
        cmd_write = 1'h1;
        cmd_wdata = word;
        @(negedge clk);
        cmd_write = 1'h0;
        // idle data shows the inverse so a stale word cannot pass
        cmd_wdata = ~word;
    endtask
endmodule // bus_master_model

/* File: verif/dcsw_monitor.sv */
// Purpose: concurrent checks on command decode and condition word
// Assumes: reference source left on bus by the bench
// Notes:   command outputs lag the latched word by one edge
`timescale 1ns/1ps
module dcsw_monitor
(
    input wire        clk,
    input wire        arst_n,
    input wire        cmd_write,
    input wire [15:0] cmd_wdata,
    input wire [15:0] drive_command_word,
    input wire [1:0]  ref_src,
    input wire        cond_trip,
    input wire        cond_error,
    input wire        cond_triplock,
    input wire        cond_warning,
    input wire        cond_link_lost,
    input wire [1:0]  preset_sel,
    input wire        dc_brake_stop,
    input wire        trip_reset,
    input wire        jog,
    input wire        ramp2_sel,
    input wire [15:0] drive_condition_word
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);
    AST_LATCH: assert property (cmd_write && cmd_wdata[10] |=> drive_command_word == $past(cmd_wdata))
        else $error("valid word not latched");
    AST_IGNORE: assert property (cmd_write && !cmd_wdata[10] |=> $stable(drive_command_word))
        else $error("invalid word changed the command");
    AST_PRESET: assert property (ref_src == 2'h1 |-> preset_sel == $past(drive_command_word[1:0]))
        else $error("preset select wrong");
    AST_DC_BRAKE: assert property (dc_brake_stop ==
        ($past(drive_command_word[10]) && !$past(drive_command_word[2])))
        else $error("dc brake wrong");
    AST_TRIP_EDGE: assert property (trip_reset |-> $past(drive_command_word[7]) && !$past(drive_command_word[7], 2) ##1 !trip_reset)
        else $error("trip reset without rising bit");
    AST_JOG_RAMP: assert property ({ramp2_sel, jog} == $past(drive_command_word[9:8]))
        else $error("jog or ramp select wrong");
    AST_LINK_LOST: assert property (cond_link_lost |=> drive_condition_word == 16'h0000)
        else $error("condition word not cleared");
    AST_FAULTS: assert property (!cond_link_lost |=> drive_condition_word[7:3] == {$past(cond_warning), $past(cond_triplock), 1'h0, $past(cond_error && !cond_trip), $past(cond_trip)})
        else $error("fault bits wrong");
    cover property (trip_reset);
    cover property (cmd_write && !cmd_wdata[10]);
    cover property (cond_link_lost);
endmodule // dcsw_monitor
bind drive_control_status_word dcsw_monitor u_dcsw_monitor (.*);

/* File: verif/drive_control_status_word_tb.sv */
// Purpose: self-checking bench for the command and condition words
// Assumes: all sources on bus unless a test changes them
// Notes:   row outputs are checked two edges after the write
`timescale 1ns/1ps
module drive_control_status_word_tb;
    logic clk = 1'h0, arst_n = 1'h0, din_coast_n = 1'h1, din_start = 1'h0, din_reverse = 1'h0;
    logic din_freeze_stop = 1'h0, multi_setup = 1'h1, relay1_from_bus = 1'h1, relay2_from_bus = 1'h1;
    logic [1:0] din_ref_sel = 2'h0, din_setup_sel = 2'h0, coast_src = 2'h1, ref_src = 2'h1;
    logic [1:0] start_src = 2'h1, setup_src = 2'h1, reverse_src = 2'h1;
    logic cond_ctrl_ready = 1'h0, cond_drive_ready = 1'h0, cond_trip = 1'h0, cond_error = 1'h0;
    logic cond_triplock = 1'h0, cond_warning = 1'h0, cond_at_ref = 1'h0, cond_local = 1'h0;
    logic cond_freq_limit = 1'h0, cond_freq_nonzero = 1'h0, cond_overtemp = 1'h0;
    logic cond_voltage = 1'h0, cond_torque = 1'h0, cond_timer = 1'h0, cond_link_lost = 1'h0;
    wire cmd_write, dc_brake_stop, coast, quick_stop, freeze_freq, ramp_stop, run_permit;
    wire trip_reset, jog, ramp2_sel, relay1, relay2, reverse;
    wire [1:0] preset_sel, setup_sel;
    wire [15:0] cmd_wdata, drive_command_word, drive_condition_word;
    wire [13:0] outs = {preset_sel, dc_brake_stop, coast, quick_stop, freeze_freq, ramp_stop,
                        jog, ramp2_sel, relay1, relay2, setup_sel, reverse};
    integer miscompares = 0, n_tests = 0, cycles = 0, i;
    // command word beside expected decoded outputs
    logic [29:0] rows [4] = '{{16'h047c, 14'h0000}, {16'hffff, 14'h307f},
                              {16'h0621, 14'h1ea0}, {16'h5c26, 14'h269c}};
    drive_control_status_word u_drive_control_status_word (.*);
    bus_master_model u_bus_master_model (.*);
    always #12.5 clk = ~clk;
    always @(posedge clk)
        if (++cycles == 3000)
        begin
            miscompares++;
            conclude();
        end
    task tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    task check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task pulse_probe(input logic e);
        for (int k = 0; k < 3; k++)
        begin
            tick(1);
            check(16'(trip_reset), 16'(e && k == 0), "trip_reset");
        end
    endtask
    task conclude;
        $display("checks %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        tick(10);
        check(drive_command_word, 16'h0000, "reset word");
        check(16'({coast, ramp_stop}), 16'h0003, "reset stops");
        check(drive_condition_word, 16'h0000, "reset status");
        tick(10);
        arst_n = 1'h1;
        $display("reset test done");
        for (i = 0; i < 4; i++)
        begin
            u_bus_master_model.send(rows[i][29:14]);
            tick(2);
            check(drive_command_word, rows[i][29:14], "command word");
            check(16'(outs), 16'(rows[i][13:0]), "decoded outputs");
        end
        $display("row tests done");
        // bit 10 clear: word discarded whole
        u_bus_master_model.send(16'h0000);
        tick(2);
        check(drive_command_word, 16'h5c26, "ignored word");
        check(16'(outs), 16'h269c, "ignored outputs");
        // pin source overrides the bus coast bit
        coast_src = 2'h0;
        din_coast_n = 1'h0;
        tick(5);
        check(16'(coast), 16'h0001, "pin coast");
        din_coast_n = 1'h1;
        tick(5);
        check(16'(coast), 16'h0000, "pin run");
        coast_src = 2'h1;
        u_bus_master_model.send(16'h0448);
        tick(2);
        check(16'({freeze_freq, quick_stop, dc_brake_stop}), 16'h0005, "frozen");
        u_bus_master_model.send(16'h047c);
        u_bus_master_model.send(16'h04fc);
        pulse_probe(1'h1);
        u_bus_master_model.send(16'h04fc);
        pulse_probe(1'h0);
        // single set-up, relay 1 off the bus, direction from pins
        {multi_setup, relay1_from_bus, reverse_src} = 4'h0;
        u_bus_master_model.send(16'hffff);
        tick(2);
        check(16'(outs), 16'h3068, "setting gates");
        check(16'(run_permit), 16'h0001, "run permit");
        $display("command edge tests done");
        {cond_trip, cond_error, cond_warning, cond_at_ref, cond_torque, cond_local,
         cond_freq_limit} = 7'h7f;
        tick(2);
        check(drive_condition_word, 16'h498c, "status");
        {cond_trip, cond_warning, cond_at_ref, cond_torque, cond_local, cond_freq_limit} = 6'h00;
        {cond_ctrl_ready, cond_triplock, cond_overtemp, cond_voltage, cond_timer} = 5'h1f;
        tick(2);
        check(drive_condition_word, 16'hbe55, "status ready");
        cond_link_lost = 1'h1;
        tick(2);
        check(drive_condition_word, 16'h0000, "link lost");
        $display("status tests done");
        conclude();
    end
endmodule // drive_control_status_word_tb
